/* core/ckm_ctrl.sv */
// Control and status logic for the on-chip clock multiplier.
`timescale 1ns/1ps
`default_nettype none
`include "ckm_defs.svh"

module ckm_ctrl
   import ckm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic pll_lock_async,
   input wire logic [2:0] ext_osc_mode,
   output logic pll_enable,
   output logic pll_init,
   output logic pll_src_external,
   output logic pll_base_x4,
   output logic pll_scale_bypass,
   output logic [2:0] pll_scale_den,
   output logic pll_duty_uneven,
   output logic multiplier_ready,
   output logic p0_2_claim,
   output logic p0_3_claim
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic multiplier_enable_q;
   logic multiplier_enable_d;
   logic multiplier_initialise_q;
   logic multiplier_initialise_d;
   logic [2:0] output_scaling_factor_q;
   logic [2:0] output_scaling_factor_d;
   logic [1:0] multiplier_input_select_q;
   logic [1:0] multiplier_input_select_d;
   ckm_state_e state_q;
   ckm_state_e state_d;
   logic lock_meta_q;
   logic lock_sync_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [2:0] scale_den_q;
   logic [2:0] scale_den_d;
   logic scale_bypass_q;
   logic scale_bypass_d;
   logic duty_uneven_q;
   logic duty_uneven_d;
   logic p0_2_q;
   logic p0_2_d;
   logic p0_3_q;
   logic p0_3_d;
   wire ctrl_hit;
   wire ctrl_wr;
   wire wr_enable;
   wire wr_init;
   wire init_start;
   wire base_x2;
   wire [7:0] ctrl_value;
   wire [2:0] raw_den;
   wire xmode_two_pin;
   wire xmode_one_pin;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode.

   // The write strobe counts only on the control register's own address.
   assign ctrl_hit = (sfr_addr == `CKM_CTRL_ADDR);
   assign ctrl_wr = ctrl_hit & sfr_wr;
   assign wr_enable = sfr_wdata[`CKM_BIT_ENABLE];
   assign wr_init = sfr_wdata[`CKM_BIT_INIT];

   // Initialisation is accepted only when the multiplier was already enabled.
   assign init_start = ctrl_wr & wr_init & wr_enable & multiplier_enable_q;

   // Read value; the ready bit is the state machine's view, never stored.
   assign ctrl_value = {multiplier_enable_q,
                        multiplier_initialise_q,
                        (state_q == CKM_READY),
                        output_scaling_factor_q,
                        multiplier_input_select_q};

   ////////////////////////////////////////////////////////////////////////////
   // Control register next values.

   // Bit 5 of a write is dropped since ready is read-only. Clearing enable
   // also drops the initialise bit so that a new sequence must follow.
   always_comb begin
      multiplier_enable_d = multiplier_enable_q;
      multiplier_initialise_d = multiplier_initialise_q;
      output_scaling_factor_d = output_scaling_factor_q;
      multiplier_input_select_d = multiplier_input_select_q;
      if (ctrl_wr) begin
         multiplier_enable_d = wr_enable;
         multiplier_initialise_d = wr_init & wr_enable;
         output_scaling_factor_d = sfr_wdata[`CKM_SCALE_HI:`CKM_SCALE_LO];
         multiplier_input_select_d = sfr_wdata[`CKM_SEL_HI:`CKM_SEL_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Multiplier state machine.

   // A lock that drops while ready sends the loop back to locking, so the
   // ready bit clears three enabled edges after the loop loses lock.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         CKM_OFF: begin
            // An initialise write right behind the enabling write is still honoured.
            if (init_start) begin
               state_d = CKM_LOCKING;
            end else if (multiplier_enable_q) begin
               state_d = CKM_ENABLED;
            end
         end
         CKM_ENABLED: begin
            if (init_start) begin
               state_d = CKM_LOCKING;
            end
         end
         CKM_LOCKING: begin
            if (lock_sync_q) begin
               state_d = CKM_READY;
            end
         end
         CKM_READY: begin
            if (!lock_sync_q) begin
               state_d = CKM_LOCKING;
            end
         end
      endcase
      // Disabling overrides every other transition.
      if (!multiplier_enable_q || (ctrl_wr && !wr_enable)) begin
         state_d = CKM_OFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scaling decode.

   // Times-two bases skip the scaler; the odd denominators cannot split the
   // high and low phases evenly, so they are flagged as uneven duty.
   assign base_x2 = ~multiplier_input_select_q[1];
   assign raw_den = (output_scaling_factor_q == `CKM_SCALE_2_3) ? 3'h3 :
                    (output_scaling_factor_q == `CKM_SCALE_2_4) ? 3'h4 :
                    (output_scaling_factor_q == `CKM_SCALE_2_5) ? 3'h5 :
                    (output_scaling_factor_q == `CKM_SCALE_2_6) ? 3'h6 :
                    (output_scaling_factor_q == `CKM_SCALE_2_7) ? 3'h7 :
                    `CKM_SCALE_DEN_ONE;
   always_comb begin
      scale_bypass_d = base_x2 | (raw_den == `CKM_SCALE_DEN_ONE);
      scale_den_d = scale_bypass_d ? `CKM_SCALE_DEN_ONE : raw_den;
      duty_uneven_d = ~scale_bypass_d & raw_den[0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator pin claims.

   // The mode code comes from a register on this clock, so it is not synchronised.
   assign xmode_two_pin = (ext_osc_mode == `CKM_XMODE_XTAL) |
                          (ext_osc_mode == `CKM_XMODE_XTAL_DIV2);
   assign xmode_one_pin = (ext_osc_mode == `CKM_XMODE_CMOS) |
                          (ext_osc_mode == `CKM_XMODE_CMOS_DIV2) |
                          (ext_osc_mode == `CKM_XMODE_RC) |
                          (ext_osc_mode == `CKM_XMODE_CAP);
   always_comb begin
      p0_2_d = xmode_two_pin;
      p0_3_d = xmode_two_pin | xmode_one_pin;
      rdata_d = ctrl_hit ? ctrl_value : 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock synchroniser; the analogue lock flag has no relation to clk_sys.

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lock_meta_q <= 1'b0;
         lock_sync_q <= 1'b0;
      end else if (clk_en) begin
         lock_meta_q <= pll_lock_async;
         lock_sync_q <= lock_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register and state.

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         multiplier_enable_q <= 1'b0;
         multiplier_initialise_q <= 1'b0;
         output_scaling_factor_q <= 3'h0;
         multiplier_input_select_q <= 2'h0;
         state_q <= CKM_OFF;
      end else if (clk_en) begin
         multiplier_enable_q <= multiplier_enable_d;
         multiplier_initialise_q <= multiplier_initialise_d;
         output_scaling_factor_q <= output_scaling_factor_d;
         multiplier_input_select_q <= multiplier_input_select_d;
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= `CKM_CTRL_RESET;
         scale_den_q <= `CKM_SCALE_DEN_ONE;
         scale_bypass_q <= 1'b1;
         duty_uneven_q <= 1'b0;
         p0_2_q <= 1'b0;
         p0_3_q <= 1'b0;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
         scale_den_q <= scale_den_d;
         scale_bypass_q <= scale_bypass_d;
         duty_uneven_q <= duty_uneven_d;
         p0_2_q <= p0_2_d;
         p0_3_q <= p0_3_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output drive.

   // Enable and source follow the register, and initialise follows the LOCKING and READY
   // states, so the analogue loop sees a change one edge after the write.
   assign sfr_rdata = rdata_q;
   assign pll_enable = multiplier_enable_q;
   assign pll_init = (state_q == CKM_LOCKING) | (state_q == CKM_READY);
   assign pll_src_external = multiplier_input_select_q[0];
   assign pll_base_x4 = multiplier_input_select_q[1];
   assign pll_scale_bypass = scale_bypass_q;
   assign pll_scale_den = scale_den_q;
   assign pll_duty_uneven = duty_uneven_q;
   assign multiplier_ready = (state_q == CKM_READY);
   assign p0_2_claim = p0_2_q;
   assign p0_3_claim = p0_3_q;

endmodule
`default_nettype wire

/* core/ckm_defs.svh */
// Constants for the clock multiplier control block.
// Functional notes
// - Writing one to the initialise bit after enabling starts initialisation and lock.
// - The read-only ready bit reads one only once the loop is locked.
// - Select 00/01/10/11 gives internal x2, external x2, internal x4, external x4.
// - Scaling field 000b delivers the unscaled base output.
// - The scaling field applies factors 1, 2/3, 2/4, 2/5, 2/6 or 2/7.
// - With a times-two base selected the scaling field is ignored.
// - Some scaling settings give an output duty cycle other than half.
// - Crystal or resonator mode claims pins P0.2 and P0.3 as terminals.
// - Capacitor, RC or CMOS clock mode claims only pin P0.3.
`ifndef CKM_DEFS_SVH
`define CKM_DEFS_SVH

// Register location on the special function register bus.
`define CKM_CTRL_ADDR 8'h97
`define CKM_CTRL_RESET 8'h00

// Field positions inside the control register.
`define CKM_BIT_ENABLE 7
`define CKM_BIT_INIT 6
`define CKM_BIT_READY 5
`define CKM_SCALE_HI 4
`define CKM_SCALE_LO 2
`define CKM_SEL_HI 1
`define CKM_SEL_LO 0

// Scaling field codes and the matching denominators of the 2/n factor.
`define CKM_SCALE_NONE 3'h0
`define CKM_SCALE_2_3 3'h2
`define CKM_SCALE_2_4 3'h3
`define CKM_SCALE_2_5 3'h4
`define CKM_SCALE_2_6 3'h5
`define CKM_SCALE_2_7 3'h6
`define CKM_SCALE_DEN_ONE 3'h1

// External oscillator mode codes.
`define CKM_XMODE_OFF 3'h0
`define CKM_XMODE_CMOS 3'h2
`define CKM_XMODE_CMOS_DIV2 3'h3
`define CKM_XMODE_RC 3'h4
`define CKM_XMODE_CAP 3'h5
`define CKM_XMODE_XTAL 3'h6
`define CKM_XMODE_XTAL_DIV2 3'h7

`endif

/* core/ckm_pkg.sv */
// Types shared by the clock multiplier control block.
package ckm_pkg;

   // Multiplier control states, Gray coded along OFF, ENABLED, LOCKING, READY.
   typedef enum logic [1:0] {
      CKM_OFF = 2'b00,
      CKM_ENABLED = 2'b01,
      CKM_LOCKING = 2'b11,
      CKM_READY = 2'b10
   } ckm_state_e;

   // Base source of the multiplier.
   typedef enum logic [1:0] {
      CKM_INT_X2 = 2'b00,
      CKM_EXT_X2 = 2'b01,
      CKM_INT_X4 = 2'b10,
      CKM_EXT_X4 = 2'b11
   } ckm_sel_e;

endpackage

/* testbench/ckm_ctrl_checker.sv */
// Assertion checker for the clock multiplier control block.
`timescale 1ns/1ps
`default_nettype none
module ckm_ctrl_checker (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic pll_lock_async,
   input wire logic [2:0] ext_osc_mode,
   input wire logic pll_enable,
   input wire logic pll_init,
   input wire logic pll_src_external,
   input wire logic pll_base_x4,
   input wire logic pll_scale_bypass,
   input wire logic [2:0] pll_scale_den,
   input wire logic pll_duty_uneven,
   input wire logic multiplier_ready,
   input wire logic p0_2_claim,
   input wire logic p0_3_claim
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // A write that the control register takes, and the last scaling code it got.
   wire logic wr_hit = clk_en && sfr_wr && (sfr_addr == 8'h97);
   logic [2:0] code_q;
   wire logic scaled = (code_q >= 3'h2) && (code_q <= 3'h6);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) code_q <= 3'h0;
      else if (wr_hit) code_q <= sfr_wdata[4:2];
   end
   ////////////////////////////////////////
   // Each property ties an output to the inputs or other outputs that caused it.
   property p_reset; $rose(rst_b) |-> sfr_rdata == 8'h00 && !pll_enable && !multiplier_ready && pll_scale_bypass;
   endproperty
   a_reset: assert property (p_reset) else $error("state after reset is not cleared");
   property p_sel; wr_hit |=> pll_enable == $past(sfr_wdata[7]) && pll_src_external == $past(sfr_wdata[0])
      && pll_base_x4 == $past(sfr_wdata[1]);
   endproperty
   a_sel: assert property (p_sel) else $error("control fields differ from written byte");
   property p_scale; (wr_hit && sfr_wdata[1]) ##1 (clk_en && !sfr_wr) |=> pll_scale_bypass == !scaled
      && pll_scale_den == (scaled ? code_q + 3'h1 : 3'h1) && pll_duty_uneven == (scaled && !code_q[0]);
   endproperty
   a_scale: assert property (p_scale) else $error("scale decode wrong for times four base");
   property p_x2; $past(!pll_base_x4 && clk_en) |-> pll_scale_bypass && pll_scale_den == 3'h1; endproperty
   a_x2: assert property (p_x2) else $error("times two base was scaled");
   property p_init; (wr_hit && pll_enable && sfr_wdata[7:6] == 2'b11) |=> pll_init; endproperty
   a_init: assert property (p_init) else $error("initialise not started");
   property p_noinit; (wr_hit && !pll_enable) |=> !pll_init; endproperty
   a_noinit: assert property (p_noinit) else $error("initialise started while disabled");
   property p_lock; (pll_init && clk_en && pll_lock_async)[*5] |-> multiplier_ready; endproperty
   a_lock: assert property (p_lock) else $error("ready missing while locked");
   property p_unlock; (clk_en && !pll_lock_async)[*4] |-> !multiplier_ready; endproperty
   a_unlock: assert property (p_unlock) else $error("ready while unlocked");
   property p_off; (wr_hit && !sfr_wdata[7]) |=> !multiplier_ready && !pll_init && !pll_enable; endproperty
   a_off: assert property (p_off) else $error("disable did not clear ready");
   property p_rd; ($past(clk_en) && $past(sfr_addr) == 8'h97) |-> sfr_rdata[7] == $past(pll_enable)
      && sfr_rdata[5] == $past(multiplier_ready);
   endproperty
   a_rd: assert property (p_rd) else $error("read data disagrees with status");
   property p_pins; $past(clk_en) |-> p0_2_claim == ($past(ext_osc_mode) >= 3'h6)
      && p0_3_claim == ($past(ext_osc_mode) >= 3'h2);
   endproperty
   a_pins: assert property (p_pins) else $error("pin claim wrong for mode");
   c_ready: cover property ($rose(multiplier_ready));
   c_uneven: cover property (pll_duty_uneven);
   c_xtal: cover property (p0_2_claim);
endmodule
bind ckm_ctrl ckm_ctrl_checker ckm_ctrl_checker_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .pll_lock_async(pll_lock_async), .ext_osc_mode(ext_osc_mode), .pll_enable(pll_enable), .pll_init(pll_init),
   .pll_src_external(pll_src_external), .pll_base_x4(pll_base_x4), .pll_scale_bypass(pll_scale_bypass),
   .pll_scale_den(pll_scale_den), .pll_duty_uneven(pll_duty_uneven), .multiplier_ready(multiplier_ready),
   .p0_2_claim(p0_2_claim), .p0_3_claim(p0_3_claim));
`default_nettype wire

/* testbench/ckm_ctrl_tb.sv */
// Self-checking testbench for the clock multiplier control block.
`timescale 1ns/1ps
`default_nettype none
module ckm_ctrl_tb;
   logic clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, sfr_wr = 1'b0, lose_lock = 1'b0, sc;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, lock_cycles = 8'h14, sfr_rdata;
   logic [2:0] ext_osc_mode = 3'h0, den, c;
   logic pll_lock_async, pll_enable, pll_init, pll_src_external, pll_base_x4, pll_scale_bypass, pll_duty_uneven;
   logic multiplier_ready, p0_2_claim, p0_3_claim;
   int mismatches = 0, num_checks = 0, i;
   always #20 clk_sys = ~clk_sys;
   ckm_ctrl ckm_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pll_lock_async(pll_lock_async), .ext_osc_mode(ext_osc_mode),
      .pll_enable(pll_enable), .pll_init(pll_init), .pll_src_external(pll_src_external), .pll_base_x4(pll_base_x4),
      .pll_scale_bypass(pll_scale_bypass), .pll_scale_den(den), .pll_duty_uneven(pll_duty_uneven),
      .multiplier_ready(multiplier_ready), .p0_2_claim(p0_2_claim), .p0_3_claim(p0_3_claim));
   ckm_pll_model ckm_pll_model_i (.clk_sys(clk_sys), .pll_enable(pll_enable), .pll_init(pll_init),
      .lose_lock(lose_lock), .lock_cycles(lock_cycles), .pll_lock_async(pll_lock_async));
   ////////////////////////////////////////
   // Compare, count and report; the verdict is the single exit of the run.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Register bus cycles: a write is a one-cycle strobe, read data shows one cycle after the address.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk_sys);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      sfr_addr <= a;
      @(posedge clk_sys);
      #1 chk(sfr_rdata, exp);
   endtask
   // Bounded wait on the ready flag, since the lock time belongs to the loop model.
   task automatic wait_rdy(input logic lvl);
      int n;
      n = 0;
      while (multiplier_ready !== lvl && n < 100) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (multiplier_ready !== lvl) begin
         mismatches++;
         print_verdict();
      end
   endtask
   ////////////////////////////////////////
   // Main sequence: reset, decode tables, pin claims, then bring-up and teardown.
   initial begin
      repeat (15) @(posedge clk_sys);
      #1 chk({pll_scale_bypass, den, pll_enable, pll_init, multiplier_ready, p0_3_claim}, 8'h90);
      @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(8'h97, 8'h00);
      $display("test reset done");
      for (i = 0; i < 32; i++) begin
         wr(8'h97, i[7:0]);
         rd(8'h97, i[7:0]);
         c = i[4:2];
         sc = i[1] && c >= 3'h2 && c <= 3'h6;
         chk({pll_src_external, pll_base_x4, pll_scale_bypass, pll_duty_uneven, 1'b0, den},
            {i[0], i[1], !sc, sc && !c[0], 1'b0, sc ? c + 3'h1 : 3'h1});
      end
      wr(8'h97, 8'h20);
      rd(8'h97, 8'h00);
      // A write while the clock enable is low must leave the register untouched.
      @(posedge clk_sys);
      clk_en <= 1'b0;
      wr(8'h97, 8'h03);
      clk_en <= 1'b1;
      rd(8'h97, 8'h00);
      $display("test decode done");
      for (i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         ext_osc_mode <= i[2:0];
         repeat (2) @(posedge clk_sys);
         #1 chk({p0_2_claim, p0_3_claim}, {i >= 6, i >= 2});
      end
      @(posedge clk_sys);
      ext_osc_mode <= 3'h0;
      $display("test pins done");
      wr(8'h97, 8'h4E);
      rd(8'h97, 8'h0E);
      chk(pll_init, 1'b0);
      wr(8'h97, 8'h8E);
      repeat (130) @(posedge clk_sys);
      wr(8'h97, 8'hCE);
      #1 chk({pll_init, multiplier_ready}, 2'b10);
      wait_rdy(1'b1);
      rd(8'h97, 8'hEE);
      @(posedge clk_sys);
      lose_lock <= 1'b1;
      wait_rdy(1'b0);
      @(posedge clk_sys);
      lose_lock <= 1'b0;
      wait_rdy(1'b1);
      wr(8'h96, 8'h0E);
      rd(8'h97, 8'hEE);
      rd(8'h96, 8'h00);
      wr(8'h97, 8'h0E);
      #1 chk({pll_enable, pll_init, multiplier_ready}, 3'b000);
      rd(8'h97, 8'h0E);
      // The external source is running long before the loop is initialised on it.
      @(posedge clk_sys);
      lock_cycles <= 8'h00;
      ext_osc_mode <= 3'h6;
      wr(8'h97, 8'h8F);
      repeat (130) @(posedge clk_sys);
      wr(8'h97, 8'hCF);
      wait_rdy(1'b1);
      rd(8'h97, 8'hEF);
      $display("test bring up done");
      print_verdict();
   end
endmodule
`default_nettype wire

/* testbench/ckm_pll_model.sv */
// Behavioural model of the multiplier loop that reports lock.
`timescale 1ns/1ps
`default_nettype none
module ckm_pll_model (
   input wire logic clk_sys,
   input wire logic pll_enable,
   input wire logic pll_init,
   input wire logic lose_lock,
   input wire logic [7:0] lock_cycles,
   output logic pll_lock_async
);
   logic [7:0] cnt_q = 8'h00;
   initial pll_lock_async = 1'b0;
   // Lock comes only after lock_cycles of initialised running; any upset drops it at once.
   always @(posedge clk_sys) begin
      if (!pll_enable || !pll_init || lose_lock) begin
         cnt_q <= 8'h00;
         pll_lock_async <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 8'h01;
         pll_lock_async <= pll_lock_async || (cnt_q >= lock_cycles);
      end
   end
endmodule
`default_nettype wire
